/* mme_pkg.sv */
// Shared constants and packet carriers for the message mailbox engine.
// Assumes a single 25 MHz clock and a 32-bit word wide local memory.
package mme_pkg;

  // ---------------------------------------------------------------
  // Sizes and field widths
  // ---------------------------------------------------------------
  localparam int MAX_PAYLOAD = 256;  // Bytes in one packet at most.
  localparam int MAX_PKTS    = 16;   // Packets in one data message at most.
  localparam int SND_SLOTS   = 4;    // Letters the sender holds at once.
  localparam int RX_SLOTS    = 16;   // Four letters to each of four mailboxes.
  localparam int DB_DEPTH    = 16;   // Doorbell records held for the processor.
  localparam int MP_MBOXES   = 4;    // Mailboxes for multi-packet messages.
  localparam int SZ_W   = 9;
  localparam int SEQ_W  = 4;
  localparam int ID_W   = 8;
  localparam int MB_W   = 6;
  localparam int LT_W   = 2;
  localparam int INFO_W = 16;
  localparam int LEN_W  = 13;
  localparam int AW     = 32;
  localparam int DW     = 32;
  localparam int BEAT_BYTES = 4;

  // ---------------------------------------------------------------
  // Predetermined local memory areas and reset values
  // ---------------------------------------------------------------
  localparam logic [AW-1:0]   MP_BASE  = 32'h0001_0000;
  localparam logic [AW-1:0]   SP_BASE  = 32'h0002_0000;
  localparam logic [AW-1:0]   DB_BASE  = 32'h0003_0000;
  localparam logic [AW-1:0]   SLOT_SPAN = 32'h0000_1000;
  localparam logic [ID_W-1:0] TID_RST  = 8'h00;
  localparam logic [ID_W-1:0] LOCAL_ID = 8'h5A;  // Arbitrary own identifier.

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MME_DONE, MME_RETRY, MME_ERROR} mme_stat_e;
  typedef enum logic {MME_DATA, MME_BELL} mme_kind_e;

  typedef struct packed {
    mme_kind_e         kind;
    logic [ID_W-1:0]   src;
    logic [ID_W-1:0]   dst;
    logic [ID_W-1:0]   tid;
    logic [MB_W-1:0]   mbox;
    logic [LT_W-1:0]   letter;
    logic [SEQ_W-1:0]  seq;
    logic              last;
    logic [SZ_W-1:0]   ssize;
    logic [SZ_W-1:0]   psize;
    logic [INFO_W-1:0] info;
  } mme_hdr_s;

  typedef struct packed {
    mme_kind_e         kind;
    logic [ID_W-1:0]   dst;
    logic [MB_W-1:0]   mbox;
    logic [LT_W-1:0]   letter;
    logic [AW-1:0]     base;
    logic [LEN_W-1:0]  len;
    logic [SZ_W-1:0]   ssize;
    logic [INFO_W-1:0] info;
  } mme_cmd_s;

  typedef struct packed {
    logic [ID_W-1:0] peer;
    logic [ID_W-1:0] tid;
    mme_stat_e       stat;
  } mme_rsp_s;

endpackage

/* mme_engine.sv */
// Message mailbox engine: segments outgoing messages, reassembles incoming
// ones into local memory and records doorbells.
// Assumes memory read data one cycle after the read strobe and that the
// fabric holds a packet header steady for all beats of that packet.
//
// Contract
// - at most sixteen packets per data message
// - payload never above 256 bytes
// - all packets equal size except final
// - header carries common payload size
// - header carries this packet's payload size
// - header carries sequence position
// - receive address from sequence and size
// - four letters to four mailboxes
// - mailbox 0 highest priority, preempts lower
// - single packet: four letters, 64 mailboxes
// - single packet mailbox 0 highest, 63 lowest
// - limits chosen per direction by parameters; only the send side has them, receive uses the fixed MAX_PAYLOAD
// - sender reads message from local memory
// - long message segmented before sending
// - completed message stored then processor notified; a single packet notifies in the cycle of its write
// - doorbell has header information, no payload
// - doorbell stored then processor notified; DB_EVENT_OUT rises in the cycle of the record write
// - busy mailbox or doorbell answers retry
// - retried request is sent again
// - transaction identifier unused until response
module mme_engine
  import mme_pkg::*;
#(
  parameter int TX_MAX_PAYLOAD = mme_pkg::MAX_PAYLOAD,
  parameter int TX_MAX_PKTS    = mme_pkg::MAX_PKTS
)(
  input  wire logic                    CLK_IN,
  input  wire logic                    RST_N_IN,
  input  wire logic                    SND_VALID_IN,
  input  wire logic [1:0]              SND_SLOT_IN,
  input  wire mme_pkg::mme_cmd_s       SND_CMD_IN,
  output logic [mme_pkg::SND_SLOTS-1:0] SND_BUSY_OUT,
  output logic                         SND_DONE_OUT,
  output logic                         SND_ERR_OUT,
  output logic [1:0]                   SND_DSLOT_OUT,
  output logic                         MEM_RD_EN_OUT,
  output logic [mme_pkg::AW-1:0]       MEM_RD_ADDR_OUT,
  input  wire logic [mme_pkg::DW-1:0]  MEM_RD_DATA_IN,
  output mme_pkg::mme_hdr_s            TX_HDR_OUT,
  output logic                         TX_VALID_OUT,
  output logic [mme_pkg::DW-1:0]       TX_DATA_OUT,
  output logic                         TX_LAST_OUT,
  input  wire logic                    TX_READY_IN,
  input  wire logic                    RSP_VALID_IN,
  input  wire mme_pkg::mme_rsp_s       RSP_IN,
  input  wire logic                    RX_VALID_IN,
  input  wire mme_pkg::mme_hdr_s       RX_HDR_IN,
  input  wire logic [mme_pkg::DW-1:0]  RX_DATA_IN,
  input  wire logic                    RX_LAST_IN,
  output logic                         RX_READY_OUT,
  output logic                         RSPO_VALID_OUT,
  output mme_pkg::mme_rsp_s            RSPO_OUT,
  output logic                         MEM_WR_EN_OUT,
  output logic [mme_pkg::AW-1:0]       MEM_WR_ADDR_OUT,
  output logic [mme_pkg::DW-1:0]       MEM_WR_DATA_OUT,
  output logic                         MSG_DONE_OUT,
  output logic                         MSG_SINGLE_OUT,
  output logic [7:0]                   MSG_BOX_OUT,
  output logic [mme_pkg::LEN_W-1:0]    MSG_LEN_OUT,
  output logic                         DB_EVENT_OUT,
  input  wire logic                    DB_POP_IN,
  output logic [4:0]                   DB_COUNT_OUT
);
  import mme_pkg::*;

  // ---------------------------------------------------------------
  // Send side
  // ---------------------------------------------------------------
  typedef enum {ST_IDLE, ST_RD, ST_WAIT, ST_CAP, ST_BEAT, ST_RSP} mme_st_e;

  mme_st_e          st_q;
  mme_cmd_s         cmd_q [SND_SLOTS];
  logic [SND_SLOTS-1:0] pend_q;
  logic [4:0]       seq_q [SND_SLOTS];
  logic [1:0]       cur_q;
  logic [SZ_W-1:0]  off_q;
  logic [ID_W-1:0]  tid_q;
  logic             sdone_q;
  logic             serr_q;
  logic [1:0]       dslot_q;
  logic             rd_q;
  logic [AW-1:0]    rdaddr_q;
  mme_hdr_s         thdr_q;
  logic             tval_q;
  logic [DW-1:0]    tdat_q;
  logic             tlast_q;

  mme_cmd_s         cur;
  logic [LEN_W-1:0] sent;
  logic [LEN_W-1:0] rem;
  logic [SZ_W-1:0]  psz;
  logic             pick_v;
  logic [1:0]       pick_i;
  logic             cmd_bad;
  logic             rsp_hit;
  logic             beat_end;

  // Payload of the current packet; only the last one may run short.
  always_comb
  begin
    cur  = cmd_q[cur_q];
    sent = LEN_W'(seq_q[cur_q]) * LEN_W'(cur.ssize);
    rem  = cur.len - sent;
    psz  = (rem < LEN_W'(cur.ssize)) ? rem[SZ_W-1:0] : cur.ssize;
  end

  // lowest mailbox number wins, so mailbox 0 preempts between packets.
  // the same compare spans all 64 single packet mailboxes.
  always_comb
  begin
    pick_v = 1'b0;
    pick_i = 2'h0;
    for (int i = SND_SLOTS - 1; i >= 0; i--)
    begin
      if (pend_q[i] && (!pick_v || cmd_q[i].mbox <= cmd_q[pick_i].mbox))
      begin
        pick_v = 1'b1;
        pick_i = 2'(i);
      end
    end
  end

  // messages needing more than sixteen packets are refused.
  // common size must be a whole number of beats up to the limit.
  // multi-packet messages only reach the four low mailboxes.
  assign cmd_bad = (SND_CMD_IN.kind == MME_DATA) &&
    (SND_CMD_IN.ssize == 9'h000 || SND_CMD_IN.ssize > SZ_W'(TX_MAX_PAYLOAD) ||
     SND_CMD_IN.ssize[1:0] != 2'h0 || SND_CMD_IN.len == 13'h0000 ||
     SND_CMD_IN.len > LEN_W'(TX_MAX_PKTS * SND_CMD_IN.ssize) ||
     (SND_CMD_IN.len > LEN_W'(SND_CMD_IN.ssize) &&
      SND_CMD_IN.mbox >= MB_W'(MP_MBOXES)));
  assign rsp_hit  = (st_q == ST_RSP) && RSP_VALID_IN &&
                    RSP_IN.tid == tid_q && RSP_IN.peer == cur.dst;
  assign beat_end = (cur.kind == MME_BELL) ||
                    (off_q + SZ_W'(BEAT_BYTES) >= psz);

  // Letter slots: taken from software, released on done or error.
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      pend_q <= '0;
      for (int i = 0; i < SND_SLOTS; i++)
      begin
        cmd_q[i] <= '0;
        seq_q[i] <= 5'h00;
      end
    end
    else
    begin
      if (rsp_hit && RSP_IN.stat == MME_DONE)
      begin
        seq_q[cur_q] <= seq_q[cur_q] + 5'h01;
        if (thdr_q.last)
          pend_q[cur_q] <= 1'b0;
      end
      else if (rsp_hit && RSP_IN.stat == MME_ERROR)
        pend_q[cur_q] <= 1'b0;
      if (SND_VALID_IN && !pend_q[SND_SLOT_IN] && !cmd_bad)
      begin
        cmd_q[SND_SLOT_IN]  <= SND_CMD_IN;
        seq_q[SND_SLOT_IN]  <= 5'h00;
        pend_q[SND_SLOT_IN] <= 1'b1;
      end
    end
  end

  // Packet engine: one request in flight, memory word by word.
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      st_q <= ST_IDLE;
      cur_q <= 2'h0;
      off_q <= '0;
      tid_q <= TID_RST;
      rd_q <= 1'b0;
      rdaddr_q <= '0;
      thdr_q <= '0;
      tval_q <= 1'b0;
      tdat_q <= '0;
      tlast_q <= 1'b0;
      sdone_q <= 1'b0;
      serr_q <= 1'b0;
      dslot_q <= 2'h0;
    end
    else
    begin
      rd_q <= 1'b0;
      sdone_q <= 1'b0;
      serr_q <= SND_VALID_IN && !pend_q[SND_SLOT_IN] && cmd_bad;
      if (SND_VALID_IN && !pend_q[SND_SLOT_IN] && cmd_bad)
        dslot_q <= SND_SLOT_IN;
      case (st_q)
        ST_IDLE:
        begin
          if (pick_v)
          begin
            cur_q <= pick_i;
            off_q <= '0;
            st_q <= ST_RD;
          end
        end
        ST_RD:
        begin
          thdr_q <= '{kind: cur.kind, src: LOCAL_ID, dst: cur.dst, tid: tid_q,
                      mbox: cur.mbox, letter: cur.letter, seq: seq_q[cur_q][3:0],
                      last: (cur.kind == MME_BELL) || (rem <= LEN_W'(cur.ssize)),
                      ssize: cur.ssize,
                      psize: (cur.kind == MME_BELL) ? 9'h000 : psz, info: cur.info};
          if (cur.kind == MME_BELL)
          begin
            tdat_q <= '0;
            tval_q <= 1'b1;
            tlast_q <= 1'b1;
            st_q <= ST_BEAT;
          end
          else
          begin
            rd_q <= 1'b1;
            rdaddr_q <= cur.base + AW'(sent) + AW'(off_q);
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT:
          st_q <= ST_CAP;
        ST_CAP:
        begin
          tdat_q <= MEM_RD_DATA_IN;
          tval_q <= 1'b1;
          tlast_q <= beat_end;
          st_q <= ST_BEAT;
        end
        ST_BEAT:
        begin
          if (TX_READY_IN)
          begin
            tval_q <= 1'b0;
            tlast_q <= 1'b0;
            off_q <= off_q + SZ_W'(BEAT_BYTES);
            st_q <= beat_end ? ST_RSP : ST_RD;
          end
        end
        ST_RSP:
        begin
          // fresh identifier only after a response
          if (rsp_hit)
          begin
            tid_q <= tid_q + 8'h01;
            sdone_q <= (RSP_IN.stat == MME_DONE && thdr_q.last) ||
                       RSP_IN.stat == MME_ERROR;
            // A refusal in the same cycle still sets serr_q, but dslot_q gives cur_q, not the refused slot.
            serr_q <= RSP_IN.stat == MME_ERROR ||
                      (SND_VALID_IN && !pend_q[SND_SLOT_IN] && cmd_bad);
            dslot_q <= cur_q;
            st_q <= ST_IDLE;
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  assign SND_BUSY_OUT    = pend_q;
  assign SND_DONE_OUT    = sdone_q;
  assign SND_ERR_OUT     = serr_q;
  assign SND_DSLOT_OUT   = dslot_q;
  assign MEM_RD_EN_OUT   = rd_q;
  assign MEM_RD_ADDR_OUT = rdaddr_q;
  assign TX_HDR_OUT      = thdr_q;
  assign TX_VALID_OUT    = tval_q;
  assign TX_DATA_OUT     = tdat_q;
  assign TX_LAST_OUT     = tlast_q;

  // ---------------------------------------------------------------
  // Receive side
  // ---------------------------------------------------------------
  logic [RX_SLOTS-1:0] act_q;
  logic [RX_SLOTS-1:0] hlast_q;
  logic [ID_W-1:0]     own_q  [RX_SLOTS];
  logic [MAX_PKTS-1:0] got_q  [RX_SLOTS];
  logic [SEQ_W-1:0]    lseq_q [RX_SLOTS];
  logic [LEN_W-1:0]    mlen_q [RX_SLOTS];
  logic [5:0]          beat_q;
  logic                rdy_q;
  logic                ro_v_q;
  mme_rsp_s            ro_q;
  logic                wr_q;
  logic [AW-1:0]       wa_q;
  logic [DW-1:0]       wd_q;
  logic                md_q;
  logic                ms_q;
  logic [7:0]          mb_q;
  logic [LEN_W-1:0]    ml_q;
  logic                db_ev_q;
  logic [3:0]          wp_q;
  logic [4:0]          cnt_q;

  mme_hdr_s         h;
  logic             acc;
  logic             single;
  logic [3:0]       slot;
  logic             bad;
  logic             busy;
  logic             ok;
  logic [SZ_W-1:0]  boff;
  logic             cmp_v;
  logic [3:0]       cmp_i;
  logic [RX_SLOTS-1:0] full;

  // a mailbox owned by another sender or a full ring gives retry.
  // a single packet message reaches any of 64 mailboxes, no slot.
  always_comb
  begin
    h      = RX_HDR_IN;
    acc    = RX_VALID_IN && rdy_q;
    single = (h.seq == 4'h0) && h.last;
    slot   = {h.mbox[1:0], h.letter};
    boff   = SZ_W'({beat_q, 2'b00});
    bad    = (h.kind == MME_DATA) && (h.psize > SZ_W'(MAX_PAYLOAD) ||
             h.ssize > SZ_W'(MAX_PAYLOAD) || h.psize > h.ssize ||
             (!single && h.mbox >= MB_W'(MP_MBOXES)));
    busy   = (h.kind == MME_BELL) ? (cnt_q == 5'(DB_DEPTH)) :
             (!single && act_q[slot] && own_q[slot] != h.src);
    ok     = !bad && !busy;
  end

  // a slot is complete once every sequence up to the final is held.
  generate
    for (genvar g = 0; g < RX_SLOTS; g++)
    begin : g_full
      assign full[g] = act_q[g] && hlast_q[g] &&
        ((got_q[g] & ((16'h0002 << lseq_q[g]) - 16'h0001)) ==
         ((16'h0002 << lseq_q[g]) - 16'h0001));
    end
  endgenerate

  always_comb
  begin
    cmp_v = 1'b0;
    cmp_i = 4'h0;
    for (int i = RX_SLOTS - 1; i >= 0; i--)
    begin
      if (full[i])
      begin
        cmp_v = 1'b1;
        cmp_i = 4'(i);
      end
    end
  end

  // Beat counter, memory writes and the answer to each request.
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      rdy_q <= 1'b0;
      beat_q <= '0;
      ro_v_q <= 1'b0;
      ro_q <= '0;
      wr_q <= 1'b0;
      wa_q <= '0;
      wd_q <= '0;
    end
    else
    begin
      rdy_q <= 1'b1;
      ro_v_q <= acc && RX_LAST_IN;
      if (acc)
      begin
        beat_q <= RX_LAST_IN ? 6'h00 : beat_q + 6'h01;
        ro_q <= '{peer: h.src, tid: h.tid,
                  stat: bad ? MME_ERROR : (busy ? MME_RETRY : MME_DONE)};
      end
      wr_q <= acc && ok && (h.kind == MME_BELL || boff < h.psize);
      wd_q <= RX_DATA_IN;
      if (h.kind == MME_BELL)
      begin
        wa_q <= DB_BASE + AW'({wp_q, 2'b00});
        wd_q <= {h.src, h.info, 8'h00};
      end
      else if (single)
        wa_q <= SP_BASE + AW'({h.mbox, h.letter}) * AW'(MAX_PAYLOAD) + AW'(boff);
      else
        wa_q <= MP_BASE + AW'(slot) * SLOT_SPAN +
                AW'(h.seq) * AW'(h.ssize) + AW'(boff);
    end
  end

  // Reassembly slots, one per mailbox and letter pair.
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      act_q <= '0;
      hlast_q <= '0;
      for (int i = 0; i < RX_SLOTS; i++)
      begin
        own_q[i] <= '0;
        got_q[i] <= '0;
        lseq_q[i] <= '0;
        mlen_q[i] <= '0;
      end
    end
    else
    begin
      if (cmp_v && !(acc && RX_LAST_IN && single && ok))
      begin
        act_q[cmp_i] <= 1'b0;
        hlast_q[cmp_i] <= 1'b0;
        got_q[cmp_i] <= '0;
      end
      if (acc && ok && h.kind == MME_DATA && !single)
      begin
        act_q[slot] <= 1'b1;
        own_q[slot] <= h.src;
        if (RX_LAST_IN)
        begin
          got_q[slot][h.seq] <= 1'b1;
          if (h.last)
          begin
            hlast_q[slot] <= 1'b1;
            lseq_q[slot] <= h.seq;
            mlen_q[slot] <= LEN_W'(h.seq) * LEN_W'(h.ssize) + LEN_W'(h.psize);
          end
        end
      end
    end
  end

  // notify with a single packet's write, a cycle after a slot's final write; single packets first.
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      md_q <= 1'b0;
      ms_q <= 1'b0;
      mb_q <= '0;
      ml_q <= '0;
    end
    else
    begin
      md_q <= 1'b0;
      if (acc && RX_LAST_IN && ok && h.kind == MME_DATA && single)
      begin
        md_q <= 1'b1;
        ms_q <= 1'b1;
        mb_q <= {h.mbox, h.letter};
        ml_q <= LEN_W'(h.psize);
      end
      else if (cmp_v)
      begin
        md_q <= 1'b1;
        ms_q <= 1'b0;
        mb_q <= {4'h0, cmp_i};
        ml_q <= mlen_q[cmp_i];
      end
    end
  end

  // Doorbell ring: the processor pops records it has read.
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      wp_q <= '0;
      cnt_q <= '0;
      db_ev_q <= 1'b0;
    end
    else
    begin
      db_ev_q <= acc && ok && h.kind == MME_BELL;
      if (acc && ok && h.kind == MME_BELL)
        wp_q <= wp_q + 4'h1;
      cnt_q <= cnt_q + 5'(acc && ok && h.kind == MME_BELL)
                     - 5'(DB_POP_IN && cnt_q != 5'h00);
    end
  end

  assign RX_READY_OUT    = rdy_q;
  assign RSPO_VALID_OUT  = ro_v_q;
  assign RSPO_OUT        = ro_q;
  assign MEM_WR_EN_OUT   = wr_q;
  assign MEM_WR_ADDR_OUT = wa_q;
  assign MEM_WR_DATA_OUT = wd_q;
  assign MSG_DONE_OUT    = md_q;
  assign MSG_SINGLE_OUT  = ms_q;
  assign MSG_BOX_OUT     = mb_q;
  assign MSG_LEN_OUT     = ml_q;
  assign DB_EVENT_OUT    = db_ev_q;
  assign DB_COUNT_OUT    = cnt_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  tx_size_cap_a: assert property (TX_VALID_OUT |->
    TX_HDR_OUT.psize <= SZ_W'(TX_MAX_PAYLOAD)) else $error("payload too big");
  tx_equal_size_a: assert property (TX_VALID_OUT && !TX_HDR_OUT.last |->
    TX_HDR_OUT.psize == TX_HDR_OUT.ssize) else $error("short inner packet");
  bell_no_data_a: assert property (TX_VALID_OUT && TX_HDR_OUT.kind == MME_BELL |->
    TX_LAST_OUT && TX_HDR_OUT.psize == 9'h000) else $error("doorbell payload");
  rd_to_beat_a: assert property ($rose(MEM_RD_EN_OUT) |-> ##2
    TX_VALID_OUT && TX_DATA_OUT == $past(MEM_RD_DATA_IN)) else $error("read lost");
  wait_rsp_a: assert property (st_q == ST_RSP && !rsp_hit |=>
    st_q == ST_RSP && !TX_VALID_OUT && $stable(tid_q)) else $error("tid reused");
  retry_keep_a: assert property (rsp_hit && RSP_IN.stat == MME_RETRY |=>
    pend_q[$past(cur_q)] && st_q == ST_IDLE) else $error("retry dropped");
  busy_retry_a: assert property (acc && RX_LAST_IN && !bad && busy |=>
    RSPO_VALID_OUT && RSPO_OUT.stat == MME_RETRY) else $error("no retry");
  place_addr_a: assert property (acc && ok && !single && h.kind == MME_DATA |=>
    MEM_WR_ADDR_OUT == MP_BASE + AW'($past(slot)) * SLOT_SPAN
    + AW'($past(h.seq)) * AW'($past(h.ssize)) + AW'($past(boff)))
    else $error("bad placement");
  bell_rec_a: assert property (acc && ok && h.kind == MME_BELL |=>
    MEM_WR_EN_OUT && DB_EVENT_OUT && MEM_WR_DATA_OUT[31:24] == $past(h.src))
    else $error("doorbell record");
  done_full_a: assert property (MSG_DONE_OUT && !MSG_SINGLE_OUT |->
    |($past(full) & (16'h0001 << MSG_BOX_OUT[3:0]))) else $error("early completion");
endmodule

/* mme_far_model.sv */
// Far-side model: local memory read port and the remote fabric peer.
// Assumes one clock; read data is valid only in the cycle after a strobe.
module mme_far_model
  import mme_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        rd_en_in,
  input  wire logic [31:0] rd_addr_in,
  output logic      [31:0] rd_data_out,
  input  wire logic        tx_valid_in,
  input  wire logic        tx_last_in,
  input  wire mme_hdr_s    tx_hdr_in,
  input  wire logic        slow_in,
  input  wire logic [1:0]  retry_in,
  output logic             ready_out,
  output logic             rsp_valid_out,
  output mme_rsp_s         rsp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] left_q;
  // Stale read data is inverted each cycle so it is never trusted by luck.
  always_ff @(posedge clk_in)
    rd_data_out <= rd_en_in ? (rd_addr_in ^ 32'hA5A5_0000) : ~rd_data_out;
  // A slow peer stalls every other cycle.
  always_ff @(posedge clk_in)
    ready_out <= rst_n_in & (~slow_in | ~ready_out);
  // peer echoes the tag and dst, retrying the first packets.
  always_ff @(posedge clk_in)
  begin
    rsp_valid_out <= tx_valid_in & ready_out & tx_last_in;
    rsp_out.peer <= tx_hdr_in.dst;
    rsp_out.tid <= tx_hdr_in.tid;
    rsp_out.stat <= (left_q != 2'h0) ? MME_RETRY : MME_DONE;
    if (!rst_n_in)
      left_q <= retry_in;
    else if (tx_valid_in & ready_out & tx_last_in & (left_q != 2'h0))
      left_q <= left_q - 2'h1;
  end
endmodule

/* mme_engine_tb.sv */
// Testbench for the message mailbox engine with a far-side model.
// Assumes the engine's registered latencies as handed over.
module mme_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mme_pkg::*;
  logic clk, rst_n, sv, mrd, tv, tl, trdy, rspv, rv, rl, rrdy, rov, mwe, mdn;
  logic msg1, dbe, pop, sdn, serr, slow;
  logic [1:0] slot, rtry, dsl;
  logic [3:0] busy;
  logic [4:0] dbc;
  logic [7:0] mbox;
  logic [12:0] mlen;
  logic [31:0] ra, rd, td, rdat, wa, wd, ltd;
  mme_cmd_s cmd;
  mme_hdr_s th, rh;
  mme_rsp_s rsp, ro;
  mme_hdr_s hq[$];
  int error_cnt = 0;
  int num_checks = 0;
  int nerr = 0;
  mme_engine dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .SND_VALID_IN(sv), .SND_SLOT_IN(slot),
    .SND_CMD_IN(cmd), .SND_BUSY_OUT(busy), .SND_DONE_OUT(sdn), .SND_ERR_OUT(serr),
    .SND_DSLOT_OUT(dsl), .MEM_RD_EN_OUT(mrd), .MEM_RD_ADDR_OUT(ra), .MEM_RD_DATA_IN(rd),
    .TX_HDR_OUT(th), .TX_VALID_OUT(tv), .TX_DATA_OUT(td), .TX_LAST_OUT(tl),
    .TX_READY_IN(trdy), .RSP_VALID_IN(rspv), .RSP_IN(rsp), .RX_VALID_IN(rv),
    .RX_HDR_IN(rh), .RX_DATA_IN(rdat), .RX_LAST_IN(rl), .RX_READY_OUT(rrdy),
    .RSPO_VALID_OUT(rov), .RSPO_OUT(ro), .MEM_WR_EN_OUT(mwe), .MEM_WR_ADDR_OUT(wa),
    .MEM_WR_DATA_OUT(wd), .MSG_DONE_OUT(mdn), .MSG_SINGLE_OUT(msg1), .MSG_BOX_OUT(mbox),
    .MSG_LEN_OUT(mlen), .DB_EVENT_OUT(dbe), .DB_POP_IN(pop), .DB_COUNT_OUT(dbc));
  mme_far_model far_u (.clk_in(clk), .rst_n_in(rst_n), .rd_en_in(mrd), .rd_addr_in(ra),
    .rd_data_out(rd), .tx_valid_in(tv), .tx_last_in(tl), .tx_hdr_in(th), .slow_in(slow),
    .retry_in(rtry), .ready_out(trdy), .rsp_valid_out(rspv), .rsp_out(rsp));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Packets and refusals are logged at the edge, so scenarios never race them.
  always @(posedge clk)
  begin
    if (tv & trdy & tl)
    begin
      hq.push_back(th);
      ltd = td;
    end
    if (serr)
      nerr++;
  end
  task automatic chk(string nm, logic [95:0] seen, logic [95:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic mme_hdr_s hd(mme_kind_e k, logic [5:0] mb, logic [3:0] sq, logic ls,
    logic [8:0] ss, logic [8:0] ps);
    hd = '0;
    hd.kind = k;
    hd.src = 8'h21;
    hd.dst = LOCAL_ID;
    hd.mbox = mb;
    hd.seq = sq;
    hd.last = ls;
    hd.ssize = ss;
    hd.psize = ps;
    hd.info = 16'hBEEF;
  endfunction
  // One-beat packet; returns at the falling edge while the one-cycle answer stands.
  task automatic rx(mme_hdr_s h, logic [31:0] d);
    @(negedge clk);
    {rv, rl, rh, rdat} = {1'b1, 1'b1, h, d};
    @(posedge clk);
    while (!rrdy)
      @(posedge clk);
    @(negedge clk);
    rv = 0;
  endtask
  task automatic snd(logic [12:0] ln, logic [8:0] ss, logic [5:0] mb, mme_kind_e k = MME_DATA);
    @(negedge clk);
    {sv, cmd} = {1'b1, k, 8'h33, mb, 2'h0, 32'h100, ln, ss, 16'h0};
    @(negedge clk);
    sv = 0;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_send();
    slow = 1;
    slot = 2'h1;
    snd(13'd12, 9'd8, 6'd0);
    @(negedge clk);
    chk("busy", busy[1], 1);
    for (int i = 0; i < 600 && sdn !== 1'b1; i++)
      @(negedge clk);
    chk("done", {sdn, dsl}, {1'b1, 2'h1});
    chk("npkt", hq.size(), 3);
    for (int i = 0; i < 3; i++)
    begin
      chk("seq", hq[i].seq, (i == 2));
      chk("tid", hq[i].tid, i);
      chk("ssize", hq[i].ssize, 8);
      chk("psize", hq[i].psize, (i == 2) ? 4 : 8);
      chk("last", hq[i].last, (i == 2));
    end
    chk("tail", ltd, 32'hA5A5_0108);
    slot = 2'h0;
    snd(13'd0, 9'd0, 6'd0, MME_BELL);
    for (int i = 0; i < 100 && sdn !== 1'b1; i++)
      @(negedge clk);
    chk("bell_done", {sdn, dsl}, {1'b1, 2'h0});
    chk("bell_pkt", {hq.size() == 4, hq[3].kind, hq[3].last, hq[3].psize},
        {1'b1, MME_BELL, 1'b1, 9'h000});
    slow = 0;
  endtask
  task automatic t_refuse();
    slot = 2'h2;
    snd(13'd8, 9'd260, 6'd0);
    snd(13'd68, 9'd4, 6'd0);
    snd(13'd8, 9'd4, 6'd4);
    repeat (2) @(negedge clk);
    chk("refusals", nerr, 3);
    chk("ref_slot", dsl, 2);
  endtask
  task automatic t_rx();
    rx(hd(MME_DATA, 6'd5, 4'd0, 1, 9'd4, 9'd4), 32'h1234_5678);
    chk("sp_addr", wa, SP_BASE + 32'h1400);
    chk("sp_done", {mdn, msg1, mwe, rov, wd}, {4'hF, 32'h1234_5678});
    chk("sp_rsp", ro.stat, MME_DONE);
    rx(hd(MME_DATA, 6'd1, 4'd1, 1, 9'd4, 9'd4), 32'hA);
    chk("mp_addr1", wa, MP_BASE + 32'h4004);
    @(posedge clk);
    #1;
    chk("mp_early", mdn, 0);
    rx(hd(MME_DATA, 6'd1, 4'd0, 0, 9'd4, 9'd4), 32'hB);
    chk("mp_addr0", wa, MP_BASE + 32'h4000);
    @(posedge clk);
    #1;
    chk("mp_done", {mdn, mbox, mlen}, {1'b1, 8'h04, 13'd8});
    rx(hd(MME_DATA, 6'd4, 4'd0, 0, 9'd4, 9'd4), 32'hC);
    chk("mb4_err", ro.stat, MME_ERROR);
    rx(hd(MME_DATA, 6'd0, 4'd0, 1, 9'd260, 9'd260), 32'hD);
    chk("big_err", ro.stat, MME_ERROR);
  endtask
  task automatic t_bell();
    rx(hd(MME_BELL, 6'd0, 4'd0, 1, 9'd0, 9'd0), 32'h0);
    chk("db_rec", {dbe, wa, wd}, {1'b1, DB_BASE, 32'h21BE_EF00});
    for (int i = 1; i < 16; i++)
      rx(hd(MME_BELL, 6'd0, 4'd0, 1, 9'd0, 9'd0), 32'h0);
    chk("db_cnt", dbc, 16);
    rx(hd(MME_BELL, 6'd0, 4'd0, 1, 9'd0, 9'd0), 32'h0);
    chk("db_retry", ro.stat, MME_RETRY);
    @(negedge clk);
    pop = 1;
    @(negedge clk);
    pop = 0;
    @(negedge clk);
    chk("db_pop", dbc, 15);
  endtask
  // --------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    {rst_n, sv, rv, rl, pop, slow, slot, cmd, rh, rdat} = '0;
    rtry = 2'h1;
    repeat (12) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_send();
    t_refuse();
    t_rx();
    t_bell();
    tally_and_finish();
  end
  // The whole run needs well under 2000 cycles.
  initial
  begin
    #160000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
